// ---- src/pbct_bus_term.sv ----
`timescale 1ns/100ps
module pbct_bus_term #(
  parameter int ADDR_W = 32
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic req_valid_in,
  input wire logic [ADDR_W-1:0] req_addr_in,
  input wire logic req_write_in,
  input wire logic [pbct_pkg::DATA_W-1:0] req_wdata_in,
  input wire logic req_lock_in,
  input wire logic req_next_level_in,
  input wire logic [1:0] size_ack_n_in,
  input wire logic bus_fault_in,
  input wire logic halt_n_in,
  input wire logic [pbct_pkg::DATA_W-1:0] bus_data_in,
  output logic req_taken_out,
  output logic done_out,
  output logic [pbct_pkg::DATA_W-1:0] rd_data_out,
  output logic fault_entry_out,
  output logic [ADDR_W-1:0] fault_addr_out,
  output logic phys_addr_strobe_out,
  output logic phys_data_strobe_out,
  output logic read_not_write_out,
  output logic [1:0] xfer_size_out,
  output logic [ADDR_W-1:0] addr_out,
  output logic [pbct_pkg::DATA_W-1:0] data_out,
  output logic indivisible_cycle_out
);
  import pbct_pkg::*;

  pbct_state_type st_q, st_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [2:0] rem_q, rem_d, moved, width, rem_left;
  logic [1:0] ack_q, gap_cnt_q;
  logic wr_q, wr_d, gap_q, lock_q, halt_seen_q;
  logic [DATA_W-1:0] asm_q, asm_d;
  logic accept, abort, piece_end, ack_now, enter_addr, active_d;

  // Fault is taken active high here; halt and acknowledge are active low
  assign ack_now = (size_ack_n_in != ACK_NONE);
  assign enter_addr = (st_d == ST_ADDR) && (st_q != ST_ADDR);
  assign active_d = (st_d == ST_ADDR) || (st_d == ST_WAIT) || (st_d == ST_DATA);

  always_comb begin
    case (ack_q)
      ACK_PORT32: width = BYTES_LONG;
      ACK_PORT16: width = BYTES_WORD;
      default: width = BYTES_BYTE;
    endcase
    moved = (rem_q < width) ? rem_q : width;
    rem_left = rem_q - moved;
  end

  // Sequencing of one physical bus cycle and of the gaps between cycles
  always_comb begin
    st_d = st_q;
    accept = 1'b0;
    abort = 1'b0;
    piece_end = 1'b0;
    case (st_q)
      ST_IDLE: begin
        if (req_valid_in && halt_n_in) begin
          accept = 1'b1;
          st_d = ST_ADDR;
        end
      end
      ST_ADDR: st_d = ST_WAIT;
      ST_WAIT: begin
        if (bus_fault_in) begin
          abort = halt_n_in;
          st_d = halt_n_in ? ST_IDLE : ST_RETRY;
        end else if (ack_now) begin
          st_d = ST_DATA;
        end
      end
      ST_DATA: begin
        if (bus_fault_in) begin
          // Late fault one clock after acknowledge
          abort = halt_n_in;
          st_d = halt_n_in ? ST_IDLE : ST_RETRY;
        end else begin
          piece_end = 1'b1;
          if (!halt_n_in || halt_seen_q) begin
            st_d = ST_HALT;
          end else if (rem_left != BYTES_NONE) begin
            st_d = ST_ADDR;
          end else if (gap_q && (GAP_CLOCKS > 1)) begin
            st_d = ST_GAP;
          end else if (req_valid_in) begin
            accept = 1'b1;
            st_d = ST_ADDR;
          end else begin
            st_d = ST_IDLE;
          end
        end
      end
      ST_HALT: begin
        if (halt_n_in) begin
          st_d = (rem_q != BYTES_NONE) ? ST_ADDR : ST_IDLE;
        end
      end
      ST_RETRY: begin
        if (!bus_fault_in && halt_n_in) begin
          st_d = ST_ADDR;
        end
      end
      ST_GAP: begin
        if (gap_cnt_q <= GAP_LAST) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_comb begin
    addr_d = addr_q;
    rem_d = rem_q;
    wr_d = wr_q;
    asm_d = asm_q;
    if (accept) begin
      addr_d = req_addr_in;
      wr_d = req_write_in;
      rem_d = req_write_in ? BYTES_BYTE : BYTES_LONG;
    end else if (piece_end) begin
      addr_d = addr_q + ADDR_W'(moved);
      rem_d = rem_left;
    end
    // Narrow ports deliver on the upper lanes; pieces shift in
    case (moved)
      BYTES_BYTE: asm_d = {asm_q[DATA_W-9:0], bus_data_in[DATA_W-1 -: 8]};
      BYTES_WORD: asm_d = {asm_q[DATA_W-17:0], bus_data_in[DATA_W-1 -: 16]};
      default: asm_d = bus_data_in;
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_q <= ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      addr_q <= '0;
      rem_q <= BYTES_NONE;
      wr_q <= 1'b0;
      gap_q <= 1'b0;
    end else begin
      addr_q <= addr_d;
      rem_q <= rem_d;
      wr_q <= wr_d;
      if (accept) begin
        gap_q <= req_next_level_in;
      end
    end
  end

  // Acknowledge is recognized in the wait state, data captured one clock on
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ack_q <= ACK_NONE;
      asm_q <= DATA_RST;
    end else begin
      if (st_q == ST_WAIT) begin
        ack_q <= size_ack_n_in;
      end
      if (piece_end && !wr_q) begin
        asm_q <= asm_d;
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      halt_seen_q <= 1'b0;
    end else if (enter_addr) begin
      halt_seen_q <= 1'b0;
    end else if ((st_q == ST_ADDR || st_q == ST_WAIT) && !halt_n_in) begin
      halt_seen_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      gap_cnt_q <= '0;
    end else if (st_q != ST_GAP) begin
      gap_cnt_q <= GAP_LOAD;
    end else begin
      gap_cnt_q <= gap_cnt_q - 2'h1;
    end
  end

  // Lock spans the whole indivisible sequence, retries included
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lock_q <= 1'b0;
    end else if (accept) begin
      lock_q <= req_lock_in;
    end else if (abort) begin
      lock_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      phys_addr_strobe_out <= 1'b0;
      phys_data_strobe_out <= 1'b0;
      read_not_write_out <= 1'b1;
      indivisible_cycle_out <= 1'b0;
    end else begin
      phys_addr_strobe_out <= active_d;
      phys_data_strobe_out <= (st_d == ST_WAIT) || (st_d == ST_DATA)
        || (st_d == ST_ADDR && !wr_d);
      read_not_write_out <= active_d ? !wr_d : 1'b1;
      indivisible_cycle_out <= accept ? req_lock_in : (lock_q && !abort);
    end
  end

  // Address, size and data hold their last values outside cycles
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      addr_out <= '0;
      xfer_size_out <= '0;
      data_out <= DATA_RST;
    end else begin
      if (enter_addr) begin
        addr_out <= addr_d;
        xfer_size_out <= rem_d[1:0];
      end
      if (accept) begin
        data_out <= req_wdata_in;
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      req_taken_out <= 1'b0;
      done_out <= 1'b0;
      rd_data_out <= DATA_RST;
      fault_entry_out <= 1'b0;
      fault_addr_out <= '0;
    end else begin
      req_taken_out <= accept;
      done_out <= piece_end && (rem_left == BYTES_NONE);
      if (piece_end && (rem_left == BYTES_NONE) && !wr_q) begin
        rd_data_out <= asm_d;
      end
      fault_entry_out <= abort;
      if (abort) begin
        fault_addr_out <= addr_q;
      end
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  sequence s_ack_clean;
    st_q == ST_WAIT && ack_now && !bus_fault_in && halt_n_in;
  endsequence

  sequence s_quiet;
    !bus_fault_in && halt_n_in;
  endsequence

  chk_retry_lock: assert property (
    st_q == ST_RETRY && indivisible_cycle_out |=> indivisible_cycle_out)
    else $error("lock dropped during retry");
  chk_halt_idle: assert property (
    st_q == ST_IDLE && !halt_n_in |=> !phys_addr_strobe_out)
    else $error("cycle started while halted");
  chk_halt_hold: assert property (
    st_q == ST_HALT |-> !phys_addr_strobe_out && !phys_data_strobe_out
      && $stable(addr_out))
    else $error("halt state drives controls or moves address");
  chk_normal_end: assert property (
    s_ack_clean ##1 s_quiet |=> !fault_entry_out && st_q != ST_RETRY)
    else $error("clean acknowledge not ended normally");
  chk_fault_abort: assert property (
    (st_q == ST_WAIT || st_q == ST_DATA) && bus_fault_in && halt_n_in
      |=> fault_entry_out && !phys_addr_strobe_out)
    else $error("bus fault did not abort");
  chk_retry_entry: assert property (
    (st_q == ST_WAIT || st_q == ST_DATA) && bus_fault_in && !halt_n_in
      |=> st_q == ST_RETRY && !fault_entry_out)
    else $error("fault with halt did not retry");
  chk_wait_state: assert property (
    st_q == ST_WAIT && !ack_now && !bus_fault_in
      |=> st_q == ST_WAIT && phys_addr_strobe_out)
    else $error("wait state not inserted");
  chk_three_clock: assert property (
    $rose(phys_addr_strobe_out) ##1 s_ack_clean ##1 s_quiet
      |=> !phys_addr_strobe_out || $rose(st_q == ST_ADDR))
    else $error("zero wait cycle not three clocks");
  chk_level_gap: assert property (
    done_out && gap_q && st_q == ST_GAP |-> !phys_addr_strobe_out ##1 !phys_addr_strobe_out)
    else $error("next level gap too short");
  chk_piece_chain: assert property (
    st_q == ST_DATA && !bus_fault_in && halt_n_in && !halt_seen_q && rem_left != BYTES_NONE
      |=> st_q == ST_ADDR && phys_addr_strobe_out)
    else $error("narrow port pieces not back to back");
  chk_retry_wait: assert property (
    st_q == ST_RETRY && (bus_fault_in || !halt_n_in) |=> !phys_addr_strobe_out)
    else $error("retry reissued before release");
endmodule

// ---- src/pbct_pkg.sv ----
package pbct_pkg;
  // Size acknowledge encodings, active low pair
  localparam logic [1:0] ACK_NONE = 2'h3;
  localparam logic [1:0] ACK_PORT32 = 2'h0;
  localparam logic [1:0] ACK_PORT16 = 2'h1;
  localparam logic [1:0] ACK_PORT8 = 2'h2;
  // Operand byte counts
  localparam logic [2:0] BYTES_NONE = 3'h0;
  localparam logic [2:0] BYTES_BYTE = 3'h1;
  localparam logic [2:0] BYTES_WORD = 3'h2;
  localparam logic [2:0] BYTES_LONG = 3'h4;
  // Idle clocks after a next-level transfer
  localparam int GAP_CLOCKS = 2;
  localparam logic [1:0] GAP_LOAD = 2'(GAP_CLOCKS - 1);
  localparam logic [1:0] GAP_LAST = 2'h1;
  localparam int DATA_W = 32;
  localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_WAIT, ST_DATA, ST_HALT, ST_RETRY, ST_GAP
  } pbct_state_type;
endpackage

// ---- tb/pbct_mem_model.sv ----
`timescale 1ns/100ps
module pbct_mem_model (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic strobe_in,
  input wire logic [31:0] addr_in,
  input wire logic [1:0] port_in,
  input wire logic [3:0] waits_in,
  input wire logic fault_cmd_in,
  input wire logic late_in,
  output logic [1:0] size_ack_n_out,
  output logic bus_fault_out,
  output logic [31:0] bus_data_out
);
  import pbct_pkg::*;
  logic [3:0] cnt_q;
  logic [1:0] hold_q;
  logic [31:0] w;
  logic [31:0] mask;
  function automatic logic [7:0] byte_of(input logic [31:0] y);
    return y[7:0] ^ y[15:8] ^ 8'hA5;
  endfunction
  always_comb begin
    for (int i = 0; i < 4; i++) w[31-8*i -: 8] = byte_of(addr_in + 32'(i));
    mask = port_in == ACK_PORT32 ? 32'hFFFF_FFFF :
      port_in == ACK_PORT16 ? 32'hFFFF_0000 : 32'hFF00_0000;
  end
  // All answers change on the rising edge, except that reset clears them at once
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_q <= 4'h0;
      hold_q <= 2'h0;
      size_ack_n_out <= ACK_NONE;
      bus_fault_out <= 1'b0;
      bus_data_out <= 32'h0;
    end else if (bus_fault_out) begin
      if (!strobe_in) begin
        bus_fault_out <= 1'b0;
        size_ack_n_out <= ACK_NONE;
        hold_q <= 2'h0;
        cnt_q <= 4'h0;
      end
    end else if (hold_q == 2'h2) begin
      hold_q <= 2'h0;
      cnt_q <= 4'h0;
      size_ack_n_out <= ACK_NONE;
      bus_data_out <= ~bus_data_out;
    end else if (hold_q == 2'h1) begin
      hold_q <= 2'h2;
      if (fault_cmd_in && late_in) begin
        bus_fault_out <= 1'b1;
      end
    end else if (strobe_in) begin
      if (cnt_q != waits_in) begin
        cnt_q <= cnt_q + 4'h1;
      end else if (fault_cmd_in && !late_in) begin
        bus_fault_out <= 1'b1;
      end else begin
        size_ack_n_out <= port_in;
        bus_data_out <= (w & mask) | (~w & ~mask);
        hold_q <= 2'h1;
      end
    end
  end
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
  import pbct_pkg::*;
  logic clk_in = 0, nrst_in = 0, req_valid_in = 0, req_write_in = 0, req_lock_in = 0;
  logic req_next_level_in = 0, halt_n_in = 1, flt_cmd = 0, late = 0, bus_fault_in;
  logic [31:0] req_addr_in = 0, req_wdata_in = 0, bus_data_in, seed = 32'h42, a;
  logic [1:0] port = ACK_PORT32, size_ack_n_in, xfer_size_out;
  logic [3:0] waits = 0;
  logic req_taken_out, done_out, fault_entry_out, phys_addr_strobe, pds, rnw, lock;
  logic [31:0] rd_data_out, fault_addr_out, addr_out, data_out;
  logic [32:0] exp_q[$];
  logic [31:0] adr_q[$];
  logic [1:0] pt[4] = '{ACK_PORT32, ACK_PORT16, ACK_PORT8, ACK_PORT32};
  int pc[4] = '{1, 2, 4, 1};
  int fail_count = 0, compares = 0, cyc = 0, rise_cyc = 0, rises = 0, gap = 0;
  int low_run = 1, ends = 0, faults = 0, lat = 0, r0, e0, f0, n;
  pbct_bus_term u_pbct_bus_term (.clk_in(clk_in), .nrst_in(nrst_in), .req_valid_in(req_valid_in),
    .req_addr_in(req_addr_in), .req_write_in(req_write_in), .req_wdata_in(req_wdata_in),
    .req_lock_in(req_lock_in), .req_next_level_in(req_next_level_in),
    .size_ack_n_in(size_ack_n_in), .bus_fault_in(bus_fault_in), .halt_n_in(halt_n_in),
    .bus_data_in(bus_data_in), .req_taken_out(req_taken_out), .done_out(done_out),
    .rd_data_out(rd_data_out), .fault_entry_out(fault_entry_out), .fault_addr_out(fault_addr_out),
    .phys_addr_strobe_out(phys_addr_strobe), .phys_data_strobe_out(pds), .read_not_write_out(rnw),
    .xfer_size_out(xfer_size_out), .addr_out(addr_out), .data_out(data_out),
    .indivisible_cycle_out(lock));
  pbct_mem_model u_pbct_mem_model (.clk_in(clk_in), .nrst_in(nrst_in), .strobe_in(phys_addr_strobe),
    .addr_in(addr_out), .port_in(port), .waits_in(waits), .fault_cmd_in(flt_cmd),
    .late_in(late),
    .size_ack_n_out(size_ack_n_in), .bus_fault_out(bus_fault_in), .bus_data_out(bus_data_in));
  initial begin
    forever #50 clk_in = ~clk_in;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Earlier pieces of a long operand land in the upper bytes
  function automatic logic [31:0] word_at(input logic [31:0] x);
    for (int i = 0; i < 4; i++) word_at[31-8*i -: 8] = (x[7:0] + 8'(i)) ^ x[15:8] ^ 8'hA5;
  endfunction
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (exp !== got) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tick();
    @(posedge clk_in);
    #1;
    n++;
    if (n > 300) begin
      check("wait bound", 0, 1);
      stop_test();
    end
  endtask
  task automatic send(input logic w, input logic [31:0] ad, input logic nl);
    logic [31:0] d;
    d = rnd();
    req_valid_in = 1;
    req_write_in = w;
    req_addr_in = ad;
    req_wdata_in = d;
    req_next_level_in = nl;
    exp_q.push_back({w, w ? d : word_at(ad)});
    adr_q.push_back(ad);
    n = 0;
    do tick(); while (req_taken_out !== 1'b1);
  endtask
  task automatic wait_end(input int k);
    n = 0;
    while (ends < k) tick();
  endtask
  // Result monitor compares each finished operand with the queued expectation
  always @(posedge clk_in) begin
    cyc++;
    if (phys_addr_strobe === 1'b1 && low_run > 0) begin
      rises++;
      rise_cyc = cyc;
      gap = low_run;
    end
    low_run = (phys_addr_strobe === 1'b1) ? 0 : low_run + 1;
    if (done_out === 1'b1 || fault_entry_out === 1'b1) begin
      lat = cyc - rise_cyc;
      ends++;
      if (exp_q.size() == 0) check("result count", 0, 1);
      else begin
        if (fault_entry_out === 1'b1) faults++;
        if (fault_entry_out === 1'b1) check("fault_addr", adr_q[0], fault_addr_out);
        else if (exp_q[0][32]) check("data_out", exp_q[0][31:0], data_out);
        else check("rd_data", exp_q[0][31:0], rd_data_out);
        void'(exp_q.pop_front());
        void'(adr_q.pop_front());
      end
    end
  end
  initial begin
    repeat (3) @(posedge clk_in);
    #1;
    check("rnw in reset", 1, rnw);
    check("strobe in reset", 0, phys_addr_strobe);
    nrst_in = 1;
    for (int i = 0; i < 4; i++) begin
      port = pt[i];
      waits = 4'(i);
      a = rnd() & 32'hFFFF_FFFC;
      e0 = ends;
      send(0, a, 1);
      check("read data strobe", 1, pds);
      req_valid_in = 0;
      wait_end(e0 + 1);
      check("latency", pc[i] * (3 + i), lat);
      check("size", (4 / pc[i]) % 4, xfer_size_out);
      check("addr", a + 4 - 4 / pc[i], addr_out);
      $display("test read %0d done", i);
    end
    port = ACK_PORT8;
    waits = 0;
    e0 = ends;
    send(1, rnd(), 0);
    check("write data strobe", 0, pds);
    check("write direction", 0, rnw);
    req_valid_in = 0;
    tick();
    check("write data strobe", 1, pds);
    wait_end(e0 + 1);
    check("write size", 1, xfer_size_out);
    $display("test write done");
    port = ACK_PORT32;
    e0 = ends;
    r0 = rises;
    send(0, rnd() & 32'hFFFF_FFFC, 0);
    send(0, rnd() & 32'hFFFF_FFFC, 1);
    send(0, rnd() & 32'hFFFF_FFFC, 0);
    req_valid_in = 0;
    wait_end(e0 + 3);
    check("back to back rises", r0 + 2, rises);
    check("next level gap", GAP_CLOCKS, gap);
    $display("test sequence done");
    for (int k = 0; k < 2; k++) begin
      late = (k == 1);
      e0 = ends;
      f0 = faults;
      flt_cmd = 1;
      send(0, a, 1);
      req_valid_in = 0;
      wait_end(e0 + 1);
      flt_cmd = 0;
      check("fault entry", f0 + 1, faults);
      $display("test fault %0d done", k);
    end
    for (int k = 0; k < 2; k++) begin
      late = (k == 1);
      e0 = ends;
      r0 = rises;
      f0 = faults;
      flt_cmd = 1;
      req_lock_in = 1;
      send(0, a, 1);
      req_valid_in = 0;
      halt_n_in = 0;
      repeat (4) tick();
      flt_cmd = 0;
      check("lock in retry", 1, lock);
      check("strobe in retry", 0, phys_addr_strobe);
      halt_n_in = 1;
      wait_end(e0 + 1);
      check("retry rises", r0 + 2, rises);
      check("retry faults", f0, faults);
      req_lock_in = 0;
      $display("test retry %0d done", k);
    end
    late = 0;
    e0 = ends;
    r0 = rises;
    port = ACK_PORT16;
    a = rnd() & 32'hFFFF_FFFC;
    send(0, a, 1);
    req_valid_in = 0;
    halt_n_in = 0;
    repeat (10) tick();
    check("halted rises", r0 + 1, rises);
    check("halted strobe", 0, phys_addr_strobe);
    check("halted addr", a, addr_out);
    halt_n_in = 1;
    repeat (2) tick();
    halt_n_in = 0;
    wait_end(e0 + 1);
    check("step rises", r0 + 2, rises);
    halt_n_in = 1;
    tick();
    halt_n_in = 0;
    e0 = ends;
    r0 = rises;
    fork
      send(0, a, 0);
      begin
        repeat (5) tick();
        check("halted start", r0, rises);
        halt_n_in = 1;
      end
    join
    req_valid_in = 0;
    wait_end(e0 + 1);
    $display("test halt done");
    stop_test();
  end
endmodule
